/* src/pbm_regs.svh */
// constants of the peripheral bus access map
`ifndef PBM_REGS_SVH
`define PBM_REGS_SVH
`define PBM_X8_SPACE     3'h7
`define PBM_X16_SPACE    3'h6
`define PBM_VIEW_OFFSET  16'h2000
`define PBM_WIN_LSB      7
`define PBM_WIN_MSB      12
`define PBM_WIN_COUNT    64
`define PBM_WIN_MAP      64'hff9fb7831f000051
`define PBM_SFR_SEC_TOP  8'h7f
`define PBM_SFR_PSW      8'hd0
`define PBM_SFR_ACC      8'he0
`define PBM_SFR_B        8'hf0
`define PBM_HAZ_GAP      2'h1
`define PBM_GAP_MAX      2'h3
`endif

/* src/pbm_pkg.sv */
// types of the peripheral bus access map
`default_nettype none
package pbm_pkg;
  typedef enum logic [1:0] {
    PBM_M_CPU  = 2'h0,
    PBM_M_XFER = 2'h1,
    PBM_M_EVT  = 2'h2
  } pbm_master_t;
  typedef enum logic [1:0] {
    PBM_PAIR_LO = 2'h1,
    PBM_PAIR_HI = 2'h2
  } pbm_pair_t;
endpackage
`default_nettype wire

/* src/pbm_win_decode.sv */
// window decoder of the external-data peripheral space
`timescale 1ns/1ns
`default_nettype none
`include "pbm_regs.svh"
module pbm_win_decode #(
  parameter int          NWIN = `PBM_WIN_COUNT,
  parameter logic [63:0] WMAP = `PBM_WIN_MAP
) (
  input  wire logic            addr_valid,
  input  wire logic [15:0]     addr,
  output logic      [NWIN-1:0] sel
);
  wire [5:0] win_idx = addr[`PBM_WIN_MSB:`PBM_WIN_LSB];
  wire       in_space = addr[15:13] == `PBM_X8_SPACE;
  // unassigned windows never select, so a stray access hits nothing
  genvar i;
  generate
    if (NWIN != 64) begin : g_bad
      $error("pbm_win_decode serves exactly 64 windows");
    end
    for (i = 0; i < NWIN; i++) begin : g_win
      assign sel[i] = addr_valid & in_space & WMAP[i]
                      & (win_idx == 6'(i));
    end
  endgenerate
endmodule
`default_nettype wire

/* src/pbm_access_map.sv */
// peripheral bus fabric: window decode, special-register maps, hazard stall
`timescale 1ns/1ns
`default_nettype none
`include "pbm_regs.svh"
module pbm_access_map #(
  parameter int NWIN = `PBM_WIN_COUNT
) (
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  input  wire logic            cpu_x_req,
  input  wire logic [15:0]     cpu_x_addr,
  input  wire logic            cpu_x_wide,
  input  wire logic            evt_x_req,
  input  wire logic [15:0]     evt_x_addr,
  input  wire logic            evt_x_wide,
  input  wire logic            evt_x_ram,
  output logic                 cpu_x_grant,
  output logic                 evt_x_grant,
  output logic      [NWIN-1:0] mod_sel,
  output logic      [15:0]     mod_addr,
  output logic                 evt_stall,
  input  wire logic            sfr_req,
  input  wire logic [1:0]      sfr_master,
  input  wire logic [7:0]      sfr_addr,
  input  wire logic            sfr_bit,
  input  wire logic            sfr_write,
  input  wire logic            sfr_wide,
  input  wire logic [7:0]      sfr_wdata,
  output logic                 sfr_ack,
  output logic                 sfr_pri_sel,
  output logic                 sfr_sec_sel,
  output logic                 sfr_reject,
  output logic                 sfr_bit_fault,
  output logic                 sfr_byte_hi,
  output logic                 sfr_pair_wr,
  output logic      [15:0]     sfr_pair_data
);
  generate
    if (NWIN != 64) begin : g_bad
      $error("pbm_access_map serves exactly 64 windows");
    end
  endgenerate

  // ==========================================================
  // external-data arbitration and view folding
  // event processor outranks the cpu on the shared bus
  assign evt_x_grant = evt_x_req & ~evt_stall;
  assign cpu_x_grant = cpu_x_req & ~evt_x_grant;
  wire [15:0] raw_addr  = evt_x_grant ? evt_x_addr : cpu_x_addr;
  wire        raw_wide  = evt_x_grant ? evt_x_wide : cpu_x_wide;
  wire        raw_valid = evt_x_grant | cpu_x_grant;
  // the 16-bit view sits a constant offset below the 8-bit view
  wire        wide_ok   = raw_addr[15:13] == `PBM_X16_SPACE;
  wire [15:0] fold_addr = raw_wide ? 16'(raw_addr + `PBM_VIEW_OFFSET)
                                   : raw_addr;
  wire        fold_ok   = raw_valid & (~raw_wide | wide_ok);
  wire [NWIN-1:0] next_mod_sel;

  pbm_win_decode #(
    .NWIN (NWIN)
  ) u_dec (
    .addr_valid (fold_ok),
    .addr       (fold_addr),
    .sel        (next_mod_sel)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mod_sel  <= '0;
      mod_addr <= 16'h0000;
    end else begin
      mod_sel  <= next_mod_sel;
      mod_addr <= fold_addr;
    end
  end

  // ==========================================================
  // hazard tracking of spaced event-processor accesses
  // only the fabric sees both masters, so it guards the hang case
  logic [1:0] evt_gap;
  logic       evt_first_shared;
  wire        haz_hit = evt_x_grant & evt_x_ram & evt_first_shared
                        & (evt_gap == `PBM_HAZ_GAP);
  wire [1:0]  next_gap = (evt_gap == `PBM_GAP_MAX) ? evt_gap
                                                   : 2'(evt_gap + 2'h1);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      evt_gap          <= `PBM_GAP_MAX;
      evt_first_shared <= 1'b0;
    end else if (evt_x_grant) begin
      evt_gap          <= 2'h0;
      evt_first_shared <= cpu_x_req & ~evt_x_ram;
    end else begin
      evt_gap          <= next_gap;
    end
  end

  // set wins: the cpu access that releases must come after the hit
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      evt_stall <= 1'b0;
    else if (haz_hit)
      evt_stall <= 1'b1;
    else if (cpu_x_req)
      evt_stall <= 1'b0;
  end

  // ==========================================================
  // special-register maps
  wire sec_hit   = sfr_addr <= `PBM_SFR_SEC_TOP;
  wire is_cpu    = sfr_master == pbm_pkg::PBM_M_CPU;
  wire bit_reg   = (sfr_addr == `PBM_SFR_PSW) | (sfr_addr == `PBM_SFR_ACC)
                   | (sfr_addr == `PBM_SFR_B);
  wire next_pri  = sfr_req & ~sec_hit;
  wire next_sec  = sfr_req & sec_hit & ~is_cpu;
  wire next_rej  = sfr_req & sec_hit & is_cpu;
  wire next_bitf = sfr_req & sfr_bit & ~bit_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sfr_ack       <= 1'b0;
      sfr_pri_sel   <= 1'b0;
      sfr_sec_sel   <= 1'b0;
      sfr_reject    <= 1'b0;
      sfr_bit_fault <= 1'b0;
    end else begin
      sfr_ack       <= sfr_req;
      sfr_pri_sel   <= next_pri;
      sfr_sec_sel   <= next_sec;
      sfr_reject    <= next_rej;
      sfr_bit_fault <= next_bitf;
    end
  end

  // ==========================================================
  // low/high pairing of 16-bit registers
  // a low byte to another address restarts the pair
  pbm_pkg::pbm_pair_t pair_st;
  logic [7:0]         pair_addr;
  logic [7:0]         pair_lo;
  wire pair_go   = sfr_req & sfr_wide & ~next_rej;
  wire take_hi   = pair_go & (pair_st == pbm_pkg::PBM_PAIR_HI)
                   & (sfr_addr == pair_addr);
  pbm_pkg::pbm_pair_t next_pair;

  always_comb begin
    next_pair = pair_st;
    case (pair_st)
      pbm_pkg::PBM_PAIR_LO: begin
        if (pair_go)
          next_pair = pbm_pkg::PBM_PAIR_HI;
      end
      pbm_pkg::PBM_PAIR_HI: begin
        if (take_hi)
          next_pair = pbm_pkg::PBM_PAIR_LO;
      end
      default: next_pair = pbm_pkg::PBM_PAIR_LO;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pair_st       <= pbm_pkg::PBM_PAIR_LO;
      pair_addr     <= 8'h00;
      pair_lo       <= 8'h00;
      sfr_byte_hi   <= 1'b0;
      sfr_pair_wr   <= 1'b0;
      sfr_pair_data <= 16'h0000;
    end else begin
      pair_st     <= next_pair;
      sfr_byte_hi <= take_hi;
      sfr_pair_wr <= take_hi & sfr_write;
      if (pair_go & ~take_hi) begin
        pair_addr <= sfr_addr;
        pair_lo   <= sfr_wdata;
      end
      if (take_hi)
        sfr_pair_data <= {sfr_wdata, pair_lo};
    end
  end

  // ==========================================================
  // checks
  sequence s_shared_first;
    evt_x_grant & cpu_x_req & ~evt_x_ram;
  endsequence
  sequence s_spaced_ram;
    ~evt_x_grant ##1 (evt_x_grant & evt_x_ram);
  endsequence

  AST_STALL_SET: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    s_shared_first ##1 s_spaced_ram |=> evt_stall)
    else $error("stall missing after hazard");
  AST_STALL_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    evt_stall & ~cpu_x_req |=> evt_stall)
    else $error("stall released without cpu access");
  AST_STALL_REL: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    evt_stall & cpu_x_req & ~haz_hit |=> ~evt_stall)
    else $error("stall not released by cpu access");
  AST_ONE_SEL: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $onehot0(mod_sel))
    else $error("more than one module select");
  AST_VIEW: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cpu_x_grant & cpu_x_wide & (cpu_x_addr[15:13] == `PBM_X16_SPACE)
    |=> mod_addr == 16'($past(cpu_x_addr) + `PBM_VIEW_OFFSET))
    else $error("16-bit view not folded by offset");
  AST_SFR_ONE: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sfr_req |=> sfr_ack ##1 (sfr_ack == $past(sfr_req)))
    else $error("special-register access not one cycle");
  AST_SEC_REJ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sfr_req & is_cpu & sec_hit |=> sfr_reject & ~sfr_sec_sel)
    else $error("cpu reached secondary map");
  AST_SEC_OK: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sfr_req & ~is_cpu & sec_hit |=> sfr_sec_sel & ~sfr_pri_sel)
    else $error("secondary map not selected");
  AST_BITADR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sfr_req & sfr_bit & (sfr_addr == `PBM_SFR_ACC) |=> ~sfr_bit_fault)
    else $error("accumulator bit access refused");
  AST_PAIR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    pair_go & (pair_st == pbm_pkg::PBM_PAIR_LO) & sfr_write
    ##1 (pair_go & sfr_write & (sfr_addr == $past(sfr_addr)))
    |=> sfr_pair_wr & (sfr_pair_data[7:0] == $past(sfr_wdata, 2)))
    else $error("low/high pair not joined");
endmodule
`default_nettype wire

/* tb/pbm_master_model.sv */
// far-side masters: cpu, transfer controller and event processor
`timescale 1ns/1ns
`default_nettype none
module pbm_master_model (
  output logic        cpu_x_req,
  output logic [15:0] cpu_x_addr,
  output logic        cpu_x_wide,
  output logic        evt_x_req,
  output logic [15:0] evt_x_addr,
  output logic        evt_x_wide,
  output logic        evt_x_ram,
  output logic        sfr_req,
  output logic [1:0]  sfr_master,
  output logic [7:0]  sfr_addr,
  output logic        sfr_bit,
  output logic        sfr_write,
  output logic        sfr_wide,
  output logic [7:0]  sfr_wdata
);
  // ==========================================================
  // idle at time zero
  initial begin
    {cpu_x_req, cpu_x_wide, evt_x_req, evt_x_wide, evt_x_ram} = '0;
    {sfr_req, sfr_master, sfr_bit, sfr_write, sfr_wide} = '0;
    {cpu_x_addr, evt_x_addr, sfr_addr, sfr_wdata} = '0;
  end
  // ==========================================================
  // external-data bus, called right after a rising edge
  // accesses come only as commanded; spacing kept by the caller
  // the shared-ram hazard is issued only when a scenario asks
  task automatic xbus(input logic cr, input logic [15:0] ca,
      input logic cw, input logic er, input logic [15:0] ea,
      input logic ew, input logic ram);
    cpu_x_req  <= cr;
    cpu_x_wide <= cw;
    // a released address shows the inverse, never a stale value
    cpu_x_addr <= cr ? ca : ~cpu_x_addr;
    evt_x_req  <= er;
    evt_x_wide <= ew;
    evt_x_ram  <= ram;
    evt_x_addr <= er ? ea : ~evt_x_addr;
  endtask
  // ==========================================================
  // special-register bus; only assigned addresses are used
  // wide accesses go low byte then high byte back to back, unless a new low byte restarts the pair
  task automatic sfr(input logic r, input logic [1:0] m,
      input logic [7:0] a, input logic b, input logic w,
      input logic wd, input logic [7:0] d);
    sfr_req    <= r;
    sfr_master <= m;
    sfr_bit    <= b;
    sfr_write  <= w;
    sfr_wide   <= wd;
    sfr_addr   <= r ? a : ~sfr_addr;
    sfr_wdata  <= r ? d : ~sfr_wdata;
  endtask
endmodule
`default_nettype wire

/* tb/periph_bus_access_map_bench.sv */
// self-checking bench of the peripheral bus access map
`timescale 1ns/1ns
`default_nettype none
module periph_bus_access_map_bench;
  logic        core_clk, rst_n, cpu_x_req, cpu_x_wide, evt_x_req;
  logic        evt_x_wide, evt_x_ram, cpu_x_grant, evt_x_grant;
  logic        evt_stall, sfr_req, sfr_bit, sfr_write, sfr_wide;
  logic        sfr_ack, sfr_pri_sel, sfr_sec_sel, sfr_reject;
  logic        sfr_bit_fault, sfr_byte_hi, sfr_pair_wr;
  logic [15:0] cpu_x_addr, evt_x_addr, mod_addr, sfr_pair_data;
  logic [63:0] mod_sel;
  logic [1:0]  sfr_master;
  logic [7:0]  sfr_addr, sfr_wdata;
  int          error_cnt, n_compared;
  pbm_access_map #(.NWIN(64)) u_dut (.core_clk, .rst_n, .cpu_x_req,
    .cpu_x_addr, .cpu_x_wide, .evt_x_req, .evt_x_addr, .evt_x_wide,
    .evt_x_ram, .cpu_x_grant, .evt_x_grant, .mod_sel, .mod_addr,
    .evt_stall, .sfr_req, .sfr_master, .sfr_addr, .sfr_bit, .sfr_write,
    .sfr_wide, .sfr_wdata, .sfr_ack, .sfr_pri_sel, .sfr_sec_sel,
    .sfr_reject, .sfr_bit_fault, .sfr_byte_hi, .sfr_pair_wr,
    .sfr_pair_data);
  pbm_master_model u_mst (.cpu_x_req, .cpu_x_addr, .cpu_x_wide,
    .evt_x_req, .evt_x_addr, .evt_x_wide, .evt_x_ram, .sfr_req,
    .sfr_master, .sfr_addr, .sfr_bit, .sfr_write, .sfr_wide, .sfr_wdata);
  // ==========================================================
  // clock and reporting
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [63:0] e,
      input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // window decode in both views, unassigned and out-of-view cases
  task automatic win_scan;
    logic [15:0] a [7] = '{16'hfc80, 16'hdc80, 16'he000, 16'hc300,
                           16'hec00, 16'he080, 16'hfc80};
    logic        w [7] = '{0, 1, 0, 1, 0, 0, 1};
    int          ix [7] = '{57, 57, 0, 6, 24, -1, -1};
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk);
      u_mst.xbus(1, a[i], w[i], 0, 0, 0, 0);
      @(posedge core_clk);
      u_mst.xbus(0, 0, 0, 0, 0, 0, 0);
      #1;
      chk("mod_sel", ix[i] < 0 ? 64'h0 : 64'h1 << ix[i], mod_sel);
      if (ix[i] >= 0)
        chk("mod_addr", a[i] + (w[i] ? 16'h2000 : 16'h0), mod_addr);
    end
  endtask
  // ==========================================================
  // peripheral, one idle cycle, shared ram: the event unit hangs
  task automatic stall_seq;
    @(posedge core_clk);
    u_mst.xbus(1, 16'hfc80, 0, 1, 16'hfe00, 0, 0);
    #1 chk("cpu_x_grant", 0, cpu_x_grant);
    @(posedge core_clk);
    u_mst.xbus(0, 0, 0, 0, 0, 0, 0);
    #1 chk("mod_sel", 64'h1 << 60, mod_sel);
    @(posedge core_clk);
    u_mst.xbus(0, 0, 0, 1, 16'hf000, 0, 1);
    @(posedge core_clk);
    u_mst.xbus(0, 0, 0, 1, 16'hf000, 0, 1);
    #1 chk("evt_stall", 1, evt_stall);
    chk("evt_x_grant", 0, evt_x_grant);
    @(posedge core_clk);
    u_mst.xbus(1, 16'hfe00, 0, 1, 16'hf000, 0, 1);
    #1 chk("cpu_x_grant", 1, cpu_x_grant);
    @(posedge core_clk);
    u_mst.xbus(0, 0, 0, 0, 0, 0, 0);
    #1 chk("evt_stall", 0, evt_stall);
  endtask
  // ==========================================================
  // special-register accesses back to back; each call checks the
  // flags {ack,pri,sec,reject,fault,hi,pair} of the previous one
  task automatic sfr_do(input logic r, input logic [1:0] m,
      input logic [7:0] a, input logic b, input logic w, input logic wd,
      input logic [7:0] d, input logic [6:0] e);
    @(posedge core_clk);
    u_mst.sfr(r, m, a, b, w, wd, d);
    #1 chk("sfr flags", e, {sfr_ack, sfr_pri_sel, sfr_sec_sel,
        sfr_reject, sfr_bit_fault, sfr_byte_hi, sfr_pair_wr});
  endtask
  task automatic sfr_seq;
    sfr_do(1, 0, 8'hd0, 1, 0, 0, 8'h00, 7'h00);
    sfr_do(1, 0, 8'h81, 1, 0, 0, 8'h00, 7'h60);
    sfr_do(1, 0, 8'h20, 0, 1, 1, 8'h00, 7'h64);
    sfr_do(1, 1, 8'h20, 0, 1, 1, 8'h11, 7'h48);
    sfr_do(1, 1, 8'h20, 0, 1, 1, 8'h22, 7'h50);
    sfr_do(1, 2, 8'h7f, 0, 0, 0, 8'h00, 7'h53);
    chk("sfr_pair_data", 16'h2211, sfr_pair_data);
    sfr_do(1, 2, 8'h30, 0, 1, 1, 8'h33, 7'h50);
    sfr_do(1, 2, 8'h40, 0, 1, 1, 8'h44, 7'h50);
    sfr_do(1, 2, 8'h40, 0, 1, 1, 8'h55, 7'h50);
    sfr_do(0, 0, 8'h00, 0, 0, 0, 8'h00, 7'h53);
    chk("sfr_pair_data", 16'h5544, sfr_pair_data);
  endtask
  // ==========================================================
  // reset in mid-run clears every registered output and drops a low byte offered in the reset cycle
  task automatic reset_seq;
    @(posedge core_clk);
    rst_n <= 1'b0;
    u_mst.sfr(1, 1, 8'h20, 0, 1, 1, 8'h66);
    @(posedge core_clk);
    rst_n <= 1'b1;
    u_mst.sfr(1, 1, 8'h20, 0, 1, 1, 8'h77);
    #1 chk("mod_sel", 0, mod_sel);
    chk("mod_addr", 0, mod_addr);
    chk("evt_stall", 0, evt_stall);
    chk("sfr_pair_data", 0, sfr_pair_data);
    chk("sfr flags", 0, {sfr_ack, sfr_pri_sel, sfr_sec_sel,
        sfr_reject, sfr_bit_fault, sfr_byte_hi, sfr_pair_wr});
    sfr_do(1, 1, 8'h20, 0, 1, 1, 8'h88, 7'h50);
    sfr_do(0, 0, 8'h00, 0, 0, 0, 8'h00, 7'h53);
    chk("sfr_pair_data", 16'h8877, sfr_pair_data);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst_n = 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    win_scan();
    stall_seq();
    sfr_seq();
    reset_seq();
    results();
  end
endmodule
`default_nettype wire
